/* stfl_map.svh */
// Register offsets, field positions, reset values and thresholds of the tuning error flags
`ifndef STFL_MAP_SVH
`define STFL_MAP_SVH

// ==========================================================================
// Byte offsets of the register words
`define STFL_STATUS_BASE 8'h00
`define STFL_TUNE_BASE 8'h10
`define STFL_UNUSED_BASE 8'h20
`define STFL_MODE_OFS 8'h30
`define STFL_IRQ_STAT_OFS 8'h34
`define STFL_IRQ_MASK_OFS 8'h38

// ==========================================================================
// Field positions inside a status word
`define STFL_RISE_ERR_BIT 9
`define STFL_TUNE_ERR_BIT 10

// ==========================================================================
// Reset values and special setting values
`define STFL_TUNE_RESET 16'h0000
`define STFL_UNUSED_RESET 16'h0000
`define STFL_TUNE_OFF 16'h0000
`define STFL_UNUSED_ON 16'h0001
`define STFL_IRQ_RESET 8'h00

// ==========================================================================
// One degree in measured_temperature units of 0.1 degree
`define STFL_ONE_DEG 17'sh0a

`endif

/* stfl_pkg.sv */
// Types shared by the tuning error flag block
`default_nettype none
package stfl_pkg;
    // Control mode selections
    typedef enum logic [2:0] {
        STFL_STANDARD,
        STFL_HEAT_COOL_NORMAL,
        STFL_HEAT_COOL_EXPANDED,
        STFL_MIX_NORMAL,
        STFL_MIX_EXPANDED
    } stfl_mode_t;

    // Per channel status from the tuning engine
    typedef struct packed {
        logic tuning_active;        // Auto_tuning run in progress
        logic starting_run;         // Run is of the starting type
        logic expect_rise;          // Temperature ought to rise
        logic param_calc_fail;      // Rise parameter not computable
        logic param_change;         // Constants, limiters, cycle, correction, filter changed
        logic auto_to_manual;       // Automatic to manual shift
        logic direction_change;     // Action direction changed
        logic pv_out_of_range;      // Temperature outside measuring range
        logic limiter_unreached;    // Output never met a limiter value
        logic sv_restart;           // Run restarted by target_setpoint change
        logic vibration_start;      // Vibration run started by disturbance
        logic [15:0] measured_temperature; // Signed, 0.1 degree units
    } stfl_chan_in_t;
endpackage : stfl_pkg
`default_nettype wire

/* stfl_flags.sv */
// Tuning error and rise parameter error flags for four channels, Wishbone slave
// Operation
// [R1] Set rise error when parameter calculation fails
// [R2] Set tuning error on setting changes while tuning
// [R3] Set tuning error on temperature out of range
// [R4] Set tuning error when output never meets limiter
// [R5] Starting run: one degree drop sets error
// [R6] Starting run: one degree rise sets error
// [R7] Clear on operation mode command falling
// [R8] Clear when channel written as unused
// [R9] Clear on forced halt command rising
// [R10] Clear when tuning setting written zero
// [R11] Clear when setpoint change restarts tuning
// [R12] Clear when vibration tuning starts
// [R13] Rise parameter is gradient plus dead time
// [R14] Standard control keeps all four channels
// [R15] Mixed control keeps channels three, four only
// [R16] Flag reads one when on, zero off
// [R17] Bits eleven to fifteen read zero
`timescale 1ns/1ps
`default_nettype none
`include "stfl_map.svh"

module stfl_flags #(
    parameter int CHANNELS = 4 // Channel count
) (
    input wire logic clk,                          // 100 MHz clock
    input wire logic sys_rst,                      // Synchronous reset, high
    input wire logic wb_cyc_i,                     // Bus cycle
    input wire logic wb_stb_i,                     // Strobe
    input wire logic wb_we_i,                      // Write enable
    input wire logic [7:0] wb_adr_i,               // Byte address
    input wire logic [3:0] wb_sel_i,               // Byte lanes
    input wire logic [31:0] wb_dat_i,              // Write data
    output logic [31:0] wb_dat_o,                  // Read data
    output logic wb_ack_o,                         // Acknowledge
    output logic irq,                              // Level interrupt
    input wire logic operation_mode_command,       // High in operation mode
    input wire logic [CHANNELS-1:0] loop_forced_halt_commands, // Forced halt per channel
    input wire stfl_pkg::stfl_chan_in_t [CHANNELS-1:0] chan_in, // Tuning engine status
    output logic [CHANNELS-1:0] rise_param_error,  // Flag copy, b9
    output logic [CHANNELS-1:0] tuning_error       // Flag copy, b10
);
    import stfl_pkg::*;

    // ======================================================================
    // Helpers

    // Channel kept in the given control mode
    function automatic logic chan_enabled(input stfl_mode_t m, input int idx);
        if (m == STFL_STANDARD) begin
            chan_enabled = 1'b1; // [R14]
        end else if (m == STFL_MIX_NORMAL || m == STFL_MIX_EXPANDED) begin
            chan_enabled = (idx >= 2); // [R15]
        end else begin
            chan_enabled = 1'b0; // Heating-cooling channels have no such flags
        end
    endfunction : chan_enabled

    // Merge write data into a 16-bit word by byte lane
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        lane_merge = old;
        if (sel[0]) begin
            lane_merge[7:0] = d[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = d[15:8];
        end
    endfunction : lane_merge

    // ======================================================================
    // State
    logic [CHANNELS-1:0] rise_err;          // b9 per channel
    logic [CHANNELS-1:0] tune_err;          // b10 per channel
    logic [15:0] tune_setting [CHANNELS];   // tuning_setting_word per channel
    logic [15:0] unused_setting [CHANNELS]; // channel_unused_setting per channel
    stfl_mode_t mode;                       // Control mode selection
    logic [7:0] irq_status;                 // Sticky events, [3:0] b9, [7:4] b10
    logic [7:0] irq_mask;                   // One enables the event
    logic op_mode_q;                        // Previous operation mode command
    logic [CHANNELS-1:0] halt_q;            // Previous halt commands
    logic [CHANNELS-1:0] start_q;           // Previous starting run level
    logic signed [16:0] ref_temp [CHANNELS]; // Temperature at starting run begin

    // Bus decode
    logic bus_req;                          // New request this cycle
    logic bus_wr;                           // Write taken this cycle
    logic [CHANNELS-1:0] wr_tune;           // Write to a tuning setting
    logic [CHANNELS-1:0] wr_unused;         // Write to an unused setting
    logic wr_mode;                          // Write to mode
    logic wr_istat;                         // Write to interrupt status
    logic wr_imask;                         // Write to interrupt mask

    // Per channel events
    logic [CHANNELS-1:0] en;                // Channel kept
    logic [CHANNELS-1:0] set_rise;          // Rise error event
    logic [CHANNELS-1:0] set_tune;          // Tuning error event
    logic [CHANNELS-1:0] drop_hit;          // Fell a degree though rising
    logic [CHANNELS-1:0] climb_hit;         // Rose a degree though falling
    logic [CHANNELS-1:0] clr;               // Any clear cause

    // ======================================================================
    // Address decode; ack is registered so a request is taken once
    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        bus_wr = bus_req && wb_we_i;
        wr_mode = bus_wr && (wb_adr_i == `STFL_MODE_OFS);
        wr_istat = bus_wr && (wb_adr_i == `STFL_IRQ_STAT_OFS);
        wr_imask = bus_wr && (wb_adr_i == `STFL_IRQ_MASK_OFS);
        // One word of each kind per channel, four bytes apart
        for (int i = 0; i < CHANNELS; i++) begin
            wr_tune[i] = bus_wr && (wb_adr_i == `STFL_TUNE_BASE + 8'(4 * i));
            wr_unused[i] = bus_wr && (wb_adr_i == `STFL_UNUSED_BASE + 8'(4 * i));
        end
    end

    // ======================================================================
    // Event and clear causes per channel
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            logic signed [16:0] pv;
            pv = 17'(signed'(chan_in[i].measured_temperature));
            en[i] = chan_enabled(mode, i);
            // Reference is only valid after the run's first cycle
            drop_hit[i] = chan_in[i].starting_run && start_q[i] && chan_in[i].expect_rise
                && (ref_temp[i] - pv >= `STFL_ONE_DEG); // [R5]
            climb_hit[i] = chan_in[i].starting_run && start_q[i] && !chan_in[i].expect_rise
                && (pv - ref_temp[i] >= `STFL_ONE_DEG); // [R6]
            // Gradient and dead time failures both arrive as one fail pulse
            set_rise[i] = en[i] && chan_in[i].tuning_active
                && chan_in[i].param_calc_fail; // [R1] [R13]
            set_tune[i] = en[i] && chan_in[i].tuning_active && (
                chan_in[i].param_change || chan_in[i].auto_to_manual
                || chan_in[i].direction_change // [R2]
                || chan_in[i].pv_out_of_range // [R3]
                || chan_in[i].limiter_unreached // [R4]
                || drop_hit[i] || climb_hit[i]);
            clr[i] = (op_mode_q && !operation_mode_command) // [R7]
                || (wr_unused[i] && lane_merge(unused_setting[i], wb_dat_i, wb_sel_i)
                    == `STFL_UNUSED_ON) // [R8]
                || (loop_forced_halt_commands[i] && !halt_q[i]) // [R9]
                || (wr_tune[i] && lane_merge(tune_setting[i], wb_dat_i, wb_sel_i)
                    == `STFL_TUNE_OFF) // [R10]
                || chan_in[i].sv_restart // [R11]
                || chan_in[i].vibration_start; // [R12]
        end
    end

    // ======================================================================
    // Flags: a set in the clear cycle wins so no event is lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rise_err <= '0;
            tune_err <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                // Channels outside the mode keep no flags
                if (!en[i]) begin
                    rise_err[i] <= 1'b0; // [R15]
                    tune_err[i] <= 1'b0; // [R15]
                end else begin
                    if (set_rise[i]) begin
                        rise_err[i] <= 1'b1; // [R1] [R16]
                    end else if (clr[i]) begin
                        rise_err[i] <= 1'b0; // [R16]
                    end
                    if (set_tune[i]) begin
                        tune_err[i] <= 1'b1; // [R2] [R16]
                    end else if (clr[i]) begin
                        tune_err[i] <= 1'b0; // [R7] [R16]
                    end
                end
            end
        end
    end

    // ======================================================================
    // Edge history of the command inputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Reset low: no false mode fall; a halt held high through reset reads as a rising edge
            op_mode_q <= 1'b0;
            halt_q <= '0;
            start_q <= '0;
        end else begin
            op_mode_q <= operation_mode_command;
            halt_q <= loop_forced_halt_commands;
            for (int i = 0; i < CHANNELS; i++) begin
                start_q[i] <= chan_in[i].starting_run;
            end
        end
    end

    // ======================================================================
    // Reference temperature caught at the start of a starting run
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                ref_temp[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (chan_in[i].starting_run && !start_q[i]) begin
                    ref_temp[i] <= 17'(signed'(chan_in[i].measured_temperature)); // [R5] [R6]
                end
            end
        end
    end

    // ======================================================================
    // Setting words and mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode <= STFL_STANDARD;
            for (int i = 0; i < CHANNELS; i++) begin
                tune_setting[i] <= `STFL_TUNE_RESET;
                unused_setting[i] <= `STFL_UNUSED_RESET;
            end
        end else begin
            // Only lane 0 carries the mode code
            if (wr_mode && wb_sel_i[0]) begin
                // Undefined codes fall back to standard control
                mode <= (wb_dat_i[2:0] > 3'(STFL_MIX_EXPANDED)) ? STFL_STANDARD
                    : stfl_mode_t'(wb_dat_i[2:0]);
            end
            for (int i = 0; i < CHANNELS; i++) begin
                if (wr_tune[i]) begin
                    tune_setting[i] <= lane_merge(tune_setting[i], wb_dat_i, wb_sel_i);
                end
                if (wr_unused[i]) begin
                    unused_setting[i] <= lane_merge(unused_setting[i], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // ======================================================================
    // Interrupt status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_status <= `STFL_IRQ_RESET;
            irq_mask <= `STFL_IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~((wr_istat && wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00))
                | {set_tune, set_rise};
            if (wr_imask && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[7:0];
            end
            // Registered, so the line follows status and mask a cycle late
            irq <= |(irq_status & irq_mask);
        end
    end

    // ======================================================================
    // Read path and ack; unmapped reads return zero and still ack
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            // Data is caught at the taking edge and holds until the next read
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= '0; // [R17]
                for (int i = 0; i < CHANNELS; i++) begin
                    if (wb_adr_i == `STFL_STATUS_BASE + 8'(4 * i)) begin
                        wb_dat_o[`STFL_RISE_ERR_BIT] <= rise_err[i]; // [R16]
                        wb_dat_o[`STFL_TUNE_ERR_BIT] <= tune_err[i]; // [R16]
                    end else if (wb_adr_i == `STFL_TUNE_BASE + 8'(4 * i)) begin
                        wb_dat_o[15:0] <= tune_setting[i];
                    end else if (wb_adr_i == `STFL_UNUSED_BASE + 8'(4 * i)) begin
                        wb_dat_o[15:0] <= unused_setting[i];
                    end
                end
                if (wb_adr_i == `STFL_MODE_OFS) begin
                    wb_dat_o[2:0] <= mode;
                end else if (wb_adr_i == `STFL_IRQ_STAT_OFS) begin
                    wb_dat_o[7:0] <= irq_status;
                end else if (wb_adr_i == `STFL_IRQ_MASK_OFS) begin
                    wb_dat_o[7:0] <= irq_mask;
                end
            end
        end
    end

    // ======================================================================
    // Registered flag copies for the control loop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rise_param_error <= '0;
            tuning_error <= '0;
        end else begin
            rise_param_error <= rise_err;
            tuning_error <= tune_err;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Set causes of each channel
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
        rise_set_a: assert property (set_rise[g] |=> rise_err[g] ##1 rise_param_error[g]) // [R1]
            else $error("rise error flag not set");
        change_set_a: assert property (en[g] && chan_in[g].tuning_active // [R2]
            && chan_in[g].auto_to_manual |=> tune_err[g])
            else $error("tuning error missed a mode shift");
        range_set_a: assert property (en[g] && chan_in[g].tuning_active // [R3]
            && chan_in[g].pv_out_of_range |=> tune_err[g])
            else $error("tuning error missed range fault");
        limiter_set_a: assert property (en[g] && chan_in[g].tuning_active // [R4]
            && chan_in[g].limiter_unreached |=> tune_err[g])
            else $error("tuning error missed limiter fault");
        drop_set_a: assert property (en[g] && chan_in[g].tuning_active && drop_hit[g] // [R5]
            |=> tune_err[g])
            else $error("tuning error missed temperature drop");
        climb_set_a: assert property (en[g] && chan_in[g].tuning_active && climb_hit[g] // [R6]
            |=> tune_err[g])
            else $error("tuning error missed temperature climb");
        // Clear causes; a set in the same cycle is allowed to win
        opmode_clr_a: assert property ($fell(operation_mode_command) && !set_tune[g] // [R7]
            |=> !tune_err[g])
            else $error("tuning error not cleared by mode return");
        unused_clr_a: assert property (wr_unused[g] && wb_sel_i[1:0] == 2'b11 // [R8]
            && wb_dat_i[15:0] == `STFL_UNUSED_ON && !set_tune[g] |=> !tune_err[g])
            else $error("tuning error not cleared by unused setting");
        halt_clr_a: assert property ($rose(loop_forced_halt_commands[g]) && !set_tune[g] // [R9]
            |=> !tune_err[g] ##1 !tuning_error[g])
            else $error("tuning error not cleared by forced halt");
        tune_off_clr_a: assert property (wr_tune[g] && wb_sel_i[1:0] == 2'b11 // [R10]
            && wb_dat_i[15:0] == `STFL_TUNE_OFF && !set_tune[g] |=> !tune_err[g])
            else $error("tuning error not cleared by tuning off");
        restart_clr_a: assert property (chan_in[g].sv_restart && !set_tune[g] // [R11]
            |=> !tune_err[g])
            else $error("tuning error not cleared by restart");
        vib_clr_a: assert property (chan_in[g].vibration_start && !set_tune[g] // [R12]
            |=> !tune_err[g])
            else $error("tuning error not cleared by vibration start");
        // Channel gating and read back
        mode_gate_a: assert property (!chan_enabled(mode, g) // [R15]
            |=> !tune_err[g] && !rise_err[g])
            else $error("flag kept on a channel not in use");
        flag_hold_a: assert property (tune_err[g] && en[g] && !clr[g] |=> tune_err[g]) // [R16]
            else $error("tuning error dropped with no clear cause");
        status_read_a: assert property (wb_ack_o && !wb_we_i // [R16]
            && wb_adr_i == `STFL_STATUS_BASE + 8'(4 * g)
            |-> wb_dat_o[`STFL_TUNE_ERR_BIT] == $past(tune_err[g])
            && wb_dat_o[`STFL_RISE_ERR_BIT] == $past(rise_err[g]))
            else $error("status word read differs from flags");
    end

    // Bus and interrupt checks
    upper_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i < `STFL_TUNE_BASE // [R17]
        |-> wb_dat_o[15:11] == 5'h00)
        else $error("status word upper bits not zero");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    irq_level_a: assert property (|(irq_status & irq_mask) |=> irq)
        else $error("interrupt low with an unmasked event");

    // Main scenarios
    tune_err_c: cover property (!tune_err[3] ##1 tune_err[3]);
    rise_err_c: cover property (!rise_err[3] ##1 rise_err[3]);
    halt_clear_c: cover property (tune_err[3] && $rose(loop_forced_halt_commands[3]));
    irq_c: cover property ($rose(irq));
    climb_hit_c: cover property (climb_hit[2]);
endmodule : stfl_flags
`default_nettype wire

/* stfl_engine_model.sv */
// Behavioural tuning engine that drives the per channel status inputs
`timescale 1ns/1ps
`default_nettype none

module stfl_engine_model (
    input wire logic clk,                              // Clock
    output var stfl_pkg::stfl_chan_in_t [3:0] chan_in  // Engine status per channel
);
    import stfl_pkg::*;

    // ==========================================================================
    // Engine control
    // Quiet engine until the bench commands activity
    initial begin
        chan_in = '0;
    end

    // Change one status bit just after an edge, so the block samples it cleanly
    task automatic put(input int ch, input int idx, input logic v);
        @(posedge clk);
        chan_in[ch][idx] <= v;
    endtask : put

    // One cycle event pulse; the block acts on every cycle it sees high
    task automatic pulse(input int ch, input int idx);
        put(ch, idx, 1'b1);
        put(ch, idx, 1'b0);
    endtask : pulse

    // New temperature in 0.1 degree units
    task automatic temp(input int ch, input logic [15:0] t);
        @(posedge clk);
        chan_in[ch].measured_temperature <= t;
    endtask : temp
endmodule : stfl_engine_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the tuning error flag block
`timescale 1ns/1ps
`default_nettype none
`include "stfl_map.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module testbench;
    import stfl_pkg::*;
    // ==========================================================================
    // Signals
    localparam int TA = 26; // Bit of tuning_active
    localparam int SR = 25; // Bit of starting_run
    localparam int ER = 24; // Bit of expect_rise
    localparam int SVR = 17; // Bit of sv_restart
    localparam int VIB = 16; // Bit of vibration_start
    logic clk = 1'b0; // Clock
    logic sys_rst = 1'b1; // Reset
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus controls
    logic [7:0] adr = 8'h00; // Address
    logic [3:0] sel = 4'h0; // Byte lanes
    logic [31:0] dat = 32'h0, rd, wb_dat_o; // Bus data
    logic wb_ack_o, irq, op_mode = 1'b1; // Handshake, interrupt, mode command
    logic [3:0] halt = 4'h0, rpe, te; // Halt commands, flag copies
    stfl_chan_in_t [3:0] chan_in; // Engine status
    int err_total = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    stfl_flags i_stfl_flags (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq), .operation_mode_command(op_mode),
        .loop_forced_halt_commands(halt), .chan_in(chan_in), .rise_param_error(rpe),
        .tuning_error(te));
    stfl_engine_model i_stfl_engine_model (.clk(clk), .chan_in(chan_in));

    // ==========================================================================
    // Bus and closing tasks
    // One classic cycle; held until ack is sampled, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h3;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50) err_total++;
    endtask : wb

    task automatic complete_run();
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // ==========================================================================
    // Scenarios
    // Reset values and read-only status word
    task automatic t_reset();
        for (int c = 0; c < 4; c++) begin
            wb(1'b0, 8'(4 * c), 0); `CHK("status reset", 32'h0, rd)
            wb(1'b0, 8'(16 + 4 * c), 0); `CHK("tune reset", 32'h0, rd)
        end
        wb(1'b1, 8'h04, 32'hffff); wb(1'b0, 8'h04, 0); `CHK("ro write", 32'h0, rd)
        wb(1'b0, 8'h3c, 0); `CHK("unmapped", 32'h0, rd)
        i_stfl_engine_model.pulse(1, 22);
        wb(1'b0, 8'h04, 0); `CHK("idle no set", 32'h0, rd)
    endtask : t_reset

    // Six pulsed set causes, each paired with a different clear cause
    task automatic t_set_clear();
        i_stfl_engine_model.put(3, TA, 1'b1);
        for (int k = 0; k < 6; k++) begin
            i_stfl_engine_model.pulse(3, 23 - k);
            wb(1'b0, 8'h0c, 0);
            `CHK("set", (k == 0) ? 32'h200 : 32'h400, rd)
            `CHK("ports", (k == 0) ? 2'b10 : 2'b01, {rpe[3], te[3]})
            case (k)
                0: begin @(posedge clk) halt[3] <= 1'b1; @(posedge clk) halt[3] <= 1'b0; end
                1: begin @(posedge clk) op_mode <= 1'b0; @(posedge clk) op_mode <= 1'b1; end
                2: begin wb(1'b1, 8'h2c, 32'h1); wb(1'b1, 8'h2c, 32'h0); end
                3: wb(1'b1, 8'h1c, 32'h0);
                4: i_stfl_engine_model.pulse(3, SVR);
                default: i_stfl_engine_model.pulse(3, VIB);
            endcase
            wb(1'b0, 8'h0c, 0); `CHK("clear", 32'h0, rd)
        end
    endtask : t_set_clear

    // Starting run: one degree the wrong way sets the error, 0.9 does not
    task automatic t_start();
        for (int r = 0; r < 2; r++) begin
            i_stfl_engine_model.temp(2, 16'd500);
            i_stfl_engine_model.put(2, ER, (r == 0));
            i_stfl_engine_model.put(2, TA, 1'b1);
            i_stfl_engine_model.put(2, SR, 1'b1);
            i_stfl_engine_model.temp(2, (r == 0) ? 16'd491 : 16'd509);
            wb(1'b0, 8'h08, 0); `CHK("near miss", 32'h0, rd)
            i_stfl_engine_model.temp(2, (r == 0) ? 16'd490 : 16'd510);
            wb(1'b0, 8'h08, 0); `CHK("one degree", 32'h400, rd)
            i_stfl_engine_model.put(2, SR, 1'b0);
            i_stfl_engine_model.pulse(2, SVR);
        end
    endtask : t_start

    // Channels kept per control mode
    task automatic t_modes();
        int m;
        logic [31:0] want;
        for (int c = 0; c < 4; c++) i_stfl_engine_model.put(c, TA, 1'b1);
        // Every mode code once, ending in standard control
        for (int i = 0; i < 5; i++) begin
            m = (i + 1) % 5;
            wb(1'b1, `STFL_MODE_OFS, m);
            for (int c = 0; c < 4; c++) begin
                i_stfl_engine_model.pulse(c, 22);
                wb(1'b0, 8'(4 * c), 0);
                want = (m == 0 || (m >= 3 && c >= 2)) ? 32'h400 : 32'h0;
                `CHK("mode chan", want, rd)
                i_stfl_engine_model.pulse(c, SVR);
            end
        end
        wb(1'b1, `STFL_MODE_OFS, 32'h4);
        wb(1'b0, `STFL_MODE_OFS, 0);
        `CHK("mode", 32'h4, rd)
        wb(1'b1, `STFL_MODE_OFS, 32'h7);
        wb(1'b0, `STFL_MODE_OFS, 0);
        `CHK("bad mode", 32'h0, rd)
    endtask : t_modes

    // Interrupt raised, cleared and masked
    task automatic t_irq();
        wb(1'b1, `STFL_IRQ_STAT_OFS, 32'hff);
        wb(1'b1, `STFL_IRQ_MASK_OFS, 32'h80);
        i_stfl_engine_model.pulse(3, 19);
        repeat (2) @(posedge clk);
        `CHK("irq high", 1'b1, irq)
        wb(1'b0, `STFL_IRQ_STAT_OFS, 0); `CHK("irq stat", 32'h80, rd)
        wb(1'b1, `STFL_IRQ_STAT_OFS, 32'h80);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        i_stfl_engine_model.pulse(3, 21);
        wb(1'b1, `STFL_IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
    endtask : t_irq

    // ==========================================================================
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_set_clear();
        t_start();
        t_modes();
        t_irq();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
